/* File: src/srs_pkg.sv */
// Constants and types for the reset and strap configuration block
package srs_pkg;
  // Register byte offsets
  localparam logic [7:0] SRS_CTRL_OFF = 8'h00;
  localparam logic [7:0] SRS_UP_LSTS_OFF = 8'h04;
  localparam logic [7:0] SRS_DN0_LSTS_OFF = 8'h08;
  localparam logic [7:0] SRS_DN1_LSTS_OFF = 8'h0C;
  localparam logic [7:0] SRS_STRAP_OFF = 8'h10;
  localparam logic [7:0] SRS_STATUS_OFF = 8'h14;
  // Field positions
  localparam int SRS_CTRL_HOLD_BIT = 0;
  localparam int SRS_LSTS_SCLK_BIT = 12;
  localparam int SRS_NUM_DN = 2;
  // Reset values
  localparam logic [31:0] SRS_ZERO = 32'h0000_0000;
  // Mode codes
  localparam logic [2:0] SRS_MODE_NORMAL = 3'h0;
  localparam logic [2:0] SRS_MODE_EEPROM = 3'h1;
  // Master bus rates
  localparam int SRS_CLK_HZ = 100_000_000;
  localparam int SRS_SLOW_HZ = 100_000;
  localparam int SRS_FAST_HZ = 400_000;
  localparam logic [9:0] SRS_SLOW_DIV = 10'(SRS_CLK_HZ / SRS_SLOW_HZ);
  localparam logic [9:0] SRS_FAST_DIV = 10'(SRS_CLK_HZ / SRS_FAST_HZ);
  // AXI responses
  localparam logic [1:0] SRS_RESP_OKAY = 2'h0;
  localparam logic [1:0] SRS_RESP_SLVERR = 2'h2;
  // Sequencer states, Gray coded
  typedef enum logic [1:0] {
    SRS_ST_RESET = 2'b00,
    SRS_ST_CAPTURE = 2'b01,
    SRS_ST_HOLD = 2'b11,
    SRS_ST_RUN = 2'b10
  } srs_state_t;
endpackage

/* File: src/srs_top.sv */
// Reset sequencer, strap capture and strap-seeded registers
`timescale 1ns/1ps
// What this block does
// - Downstream strap seeds slot clock bit of every downstream link status.
// - Software may overwrite each downstream slot clock bit separately.
// - Upstream strap seeds the upstream link status slot clock bit.
// - Software may overwrite the upstream slot clock bit.
// - Master bus runs at 100 KHz when slow strap set, else 400.
// - No software path changes master bus speed.
// - Fundamental reset clears all internal logic and resets links.
// - Hold strap keeps device in reset after sequence, buses active.
// - Registers stay readable and writable while held.
// - Clearing hold bit releases device into normal operation.
// - Mode 0 normal, 1 EEPROM init, 2 to 7 reserved.
// - EEPROM mode fetches from address set by address straps.
module srs_top
  import srs_pkg::*;
(
  input wire logic clk, // Core clock
  input wire logic reset, // Async reset, active high
  input wire logic fundamental_reset_n, // Fundamental reset, low
  input wire logic common_clock_downstream_strap, // Downstream common clock
  input wire logic common_clock_upstream_strap, // Upstream common clock
  input wire logic eeprom_bus_slow_strap, // Master bus slow select
  input wire logic reset_hold_strap, // Hold in reset after sequence
  input wire logic [2:0] switch_mode_strap, // Operating mode
  input wire logic [3:0] eeprom_addr_strap, // EEPROM address bits 4:1
  input wire logic [31:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [31:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic core_reset, // Switch core held in reset
  output logic link_reset, // Links in fundamental reset
  output logic run_normal, // Normal operation
  output logic eeprom_load_en, // EEPROM load requested
  output logic [6:0] eeprom_dev_addr, // EEPROM bus address
  output logic mode_reserved, // Reserved mode selected
  output logic master_bus_tick, // Master bus bit-rate enable
  output logic up_sclk, // Upstream slot clock config
  output logic [srs_pkg::SRS_NUM_DN-1:0] dn_sclk // Downstream slot clock config
);
  import srs_pkg::*;

  srs_state_t state_q;
  logic fr_q;
  logic [2:0] mode_q;
  logic slow_q, hold_strap_q, ccds_q, ccus_q;
  logic [3:0] eaddr_q;
  logic hold_bit_q;
  logic up_sclk_q;
  logic [SRS_NUM_DN-1:0] dn_sclk_q;
  logic [9:0] div_q;
  logic aw_q, w_q;
  logic [31:0] awaddr_q, wdata_q;
  logic [3:0] wstrb_q;
  logic all_rst;
  logic wr_fire;
  logic [9:0] div_lim;

  // Any reset source clears internal logic
  assign all_rst = reset | ~fundamental_reset_n;

  // Delay of one cycle marks the first cycle after release
  always_ff @(posedge clk or posedge all_rst)
  begin
    if (all_rst)
      fr_q <= 1'b0;
    else
      fr_q <= 1'b1;
  end

  // Sequencer: reset, capture straps, optionally hold, then run
  always_ff @(posedge clk or posedge all_rst)
  begin
    if (all_rst)
      state_q <= SRS_ST_RESET;
    else
      unique case (state_q)
        SRS_ST_RESET: state_q <= SRS_ST_CAPTURE;
        SRS_ST_CAPTURE:
          state_q <= hold_strap_q ? SRS_ST_HOLD : SRS_ST_RUN;
        SRS_ST_HOLD:
          if (!hold_bit_q)
            state_q <= SRS_ST_RUN;
        SRS_ST_RUN: state_q <= SRS_ST_RUN;
      endcase
  end

  // Capture straps at the first clock after fundamental reset release
  always_ff @(posedge clk or posedge all_rst)
  begin
    if (all_rst)
    begin
      mode_q <= SRS_MODE_NORMAL;
      slow_q <= 1'b0;
      hold_strap_q <= 1'b0;
      ccds_q <= 1'b0;
      ccus_q <= 1'b0;
      eaddr_q <= 4'h0;
    end
    else if (!fr_q)
    begin
      mode_q <= switch_mode_strap;
      slow_q <= eeprom_bus_slow_strap;
      hold_strap_q <= reset_hold_strap;
      ccds_q <= common_clock_downstream_strap;
      ccus_q <= common_clock_upstream_strap;
      eaddr_q <= eeprom_addr_strap;
    end
  end

  assign wr_fire = aw_q && w_q && !s_axi_bvalid;

  // Hold bit: set from strap at capture, cleared by software write
  always_ff @(posedge clk or posedge all_rst)
  begin
    if (all_rst)
      hold_bit_q <= 1'b0;
    else if (state_q == SRS_ST_CAPTURE)
      hold_bit_q <= hold_strap_q;
    else if (wr_fire && awaddr_q[7:0] == SRS_CTRL_OFF && wstrb_q[0])
      hold_bit_q <= wdata_q[SRS_CTRL_HOLD_BIT] & hold_bit_q;
  end

  // Slot clock bits seeded from straps, then software writable
  always_ff @(posedge clk or posedge all_rst)
  begin
    if (all_rst)
      up_sclk_q <= 1'b0;
    else if (state_q == SRS_ST_CAPTURE)
      up_sclk_q <= ccus_q;
    else if (wr_fire && awaddr_q[7:0] == SRS_UP_LSTS_OFF && wstrb_q[1])
      up_sclk_q <= wdata_q[SRS_LSTS_SCLK_BIT];
  end

  // One slot clock bit per downstream port
  for (genvar i = 0; i < SRS_NUM_DN; i++)
  begin : g_dn
    localparam logic [7:0] OFF = 8'(SRS_DN0_LSTS_OFF + 8'(4 * i));
    always_ff @(posedge clk or posedge all_rst)
    begin
      if (all_rst)
        dn_sclk_q[i] <= 1'b0;
      else if (state_q == SRS_ST_CAPTURE)
        dn_sclk_q[i] <= ccds_q;
      else if (wr_fire && awaddr_q[7:0] == OFF && wstrb_q[1])
        dn_sclk_q[i] <= wdata_q[SRS_LSTS_SCLK_BIT];
    end
  end

  // Master bus rate divider, fixed by the captured strap only
  assign div_lim = slow_q ? SRS_SLOW_DIV : SRS_FAST_DIV;
  always_ff @(posedge clk or posedge all_rst)
  begin
    if (all_rst)
      div_q <= 10'h000;
    else if (div_q >= div_lim - 10'h001)
      div_q <= 10'h000;
    else
      div_q <= div_q + 10'h001;
  end
  assign master_bus_tick = fr_q && (div_q == div_lim - 10'h001);

  // Outputs derived from state and captured straps
  assign core_reset = state_q != SRS_ST_RUN;
  assign link_reset = state_q == SRS_ST_RESET;
  assign run_normal = state_q == SRS_ST_RUN;
  assign eeprom_load_en = run_normal && mode_q == SRS_MODE_EEPROM;
  assign mode_reserved = mode_q > SRS_MODE_EEPROM;
  assign eeprom_dev_addr = {2'b10, eaddr_q, 1'b0};
  assign up_sclk = up_sclk_q;
  assign dn_sclk = dn_sclk_q;

  // AXI write channel capture, either order; fundamental reset clears it
  assign s_axi_awready = !aw_q;
  assign s_axi_wready = !w_q;
  assign s_axi_bresp = SRS_RESP_OKAY;
  always_ff @(posedge clk or posedge all_rst)
  begin
    if (all_rst)
    begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= SRS_ZERO;
      wdata_q <= SRS_ZERO;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && !aw_q)
      begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_q)
      begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire)
        s_axi_bvalid <= 1'b1;
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_q <= 1'b0;
        w_q <= 1'b0;
      end
    end
  end

  // AXI read channel, one cycle answer
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clk or posedge all_rst)
  begin
    if (all_rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= SRS_ZERO;
      s_axi_rresp <= SRS_RESP_OKAY;
    end
    else if (s_axi_arvalid && !s_axi_rvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= SRS_RESP_OKAY;
      s_axi_rdata <= SRS_ZERO;
      unique case (s_axi_araddr[7:0])
        SRS_CTRL_OFF: s_axi_rdata[SRS_CTRL_HOLD_BIT] <= hold_bit_q;
        SRS_UP_LSTS_OFF: s_axi_rdata[SRS_LSTS_SCLK_BIT] <= up_sclk_q;
        SRS_DN0_LSTS_OFF: s_axi_rdata[SRS_LSTS_SCLK_BIT] <= dn_sclk_q[0];
        SRS_DN1_LSTS_OFF: s_axi_rdata[SRS_LSTS_SCLK_BIT] <= dn_sclk_q[1];
        SRS_STRAP_OFF:
          s_axi_rdata[10:0] <= {eaddr_q, ccus_q, ccds_q,
                                hold_strap_q, slow_q, mode_q};
        SRS_STATUS_OFF:
          s_axi_rdata[3:0] <= {mode_reserved, eeprom_load_en, state_q};
        default: s_axi_rresp <= SRS_RESP_SLVERR;
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Hold strap keeps core in reset until the bit is cleared
  chk_hold_keeps_reset: assert property (@(posedge clk) disable iff (all_rst)
    (state_q == SRS_ST_HOLD && hold_bit_q) |=> core_reset)
    else $error("core left reset while hold bit set");
  // Clearing hold releases on the next cycle
  chk_hold_release: assert property (@(posedge clk) disable iff (all_rst)
    (state_q == SRS_ST_HOLD && !hold_bit_q) |=> run_normal)
    else $error("device not released after hold cleared");
  // Without hold strap the device runs two cycles after release
  chk_no_hold_run: assert property (@(posedge clk) disable iff (all_rst)
    ($rose(fr_q) && !hold_strap_q) |=> ##1 run_normal)
    else $error("device not running without hold strap");
  // Seeding of slot clock bits from straps
  chk_seed_up: assert property (@(posedge clk) disable iff (all_rst)
    (state_q == SRS_ST_CAPTURE) |=> up_sclk == ccus_q)
    else $error("upstream slot clock not seeded");
  chk_seed_dn: assert property (@(posedge clk) disable iff (all_rst)
    (state_q == SRS_ST_CAPTURE) |=> dn_sclk == {SRS_NUM_DN{ccds_q}})
    else $error("downstream slot clock not seeded");
  // Captured mode stable after capture
  chk_mode_stable: assert property (@(posedge clk) disable iff (all_rst)
    fr_q && $past(fr_q) |-> $stable(mode_q))
    else $error("captured mode changed");
  // Tick spacing with the fast speed strap: no tick in the 8 cycles after a tick
  chk_tick_rate: assert property (@(posedge clk) disable iff (all_rst)
    master_bus_tick && !slow_q |=> !master_bus_tick [*8])
    else $error("master bus tick too frequent");
  // EEPROM load only in mode one
  chk_eeprom_mode: assert property (@(posedge clk) disable iff (all_rst)
    eeprom_load_en |-> mode_q == SRS_MODE_EEPROM && !core_reset)
    else $error("eeprom load in wrong mode");
endmodule // srs_top

/* File: verif/srs_board.sv */
// Board reset and strap model facing the strap block
`timescale 1ns/1ps
module srs_board (
  input wire logic clk, // Core clock
  input wire logic rel, // Release the fundamental reset
  input wire logic [10:0] cfg, // Requested strap levels
  output logic fundamental_reset_n, // Fundamental reset, low
  output logic [10:0] straps // Strap levels at the block
);
  // Straps follow cfg only under reset and stay frozen after release
  always_ff @(posedge clk)
  begin
    fundamental_reset_n <= rel;
    if (!rel)
      straps <= cfg;
  end
endmodule // srs_board

/* File: verif/srs_top_tb.sv */
// Self-checking bench for the reset and strap block
`timescale 1ns/1ps
module srs_top_tb;
  import srs_pkg::*;
  logic clk = 0, reset = 1, rel = 0, frn;
  logic [10:0] cfg = '0, st;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, core_reset, link_reset, run_normal, eeprom_load_en;
  logic mode_reserved, master_bus_tick, up_sclk;
  logic [1:0] s_axi_bresp, s_axi_rresp, dn_sclk;
  logic [31:0] s_axi_rdata;
  logic [6:0] eeprom_dev_addr;
  int n_mismatch = 0, n_compared = 0;
  // Rows: straps {addr, mode, slow, hold, ccus, ccds}, then expected
  // {up_sclk, dn_sclk, eeprom_load_en, mode_reserved, eeprom_dev_addr}
  logic [22:0] rows [4] = '{
    {4'h0, 3'h0, 4'b0000, 1'b0, 2'b00, 2'b00, 7'h40},
    {4'hA, 3'h1, 4'b1001, 1'b0, 2'b11, 2'b10, 7'h54},
    {4'h0, 3'h2, 4'b0010, 1'b1, 2'b00, 2'b01, 7'h40},
    {4'h5, 3'h7, 4'b0011, 1'b1, 2'b11, 2'b01, 7'h4A}};

  // Free running core clock
  always #5 clk = ~clk;

  srs_board srs_board_inst (.clk, .rel, .cfg, .fundamental_reset_n(frn),
    .straps(st));
  srs_top srs_top_inst (.clk, .reset, .fundamental_reset_n(frn),
    .common_clock_downstream_strap(st[0]),
    .common_clock_upstream_strap(st[1]), .reset_hold_strap(st[2]),
    .eeprom_bus_slow_strap(st[3]), .switch_mode_strap(st[6:4]),
    .eeprom_addr_strap(st[10:7]), .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .core_reset, .link_reset,
    .run_normal, .eeprom_load_en, .eeprom_dev_addr, .mode_reserved,
    .master_bus_tick, .up_sclk, .dn_sclk);

  // Prints the counts and the verdict, then stops
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Compares one result against its expected value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // Ends the run when a wait used up its bound
  task automatic tmo(input logic hung);
    if (hung)
    begin
      n_mismatch++;
      results();
    end
  endtask

  // Bus write: address and data offered together, each released when taken
  task automatic axw(input logic [31:0] a, input logic [31:0] d);
    logic aw, w, b;
    aw = 1;
    w = 1;
    b = 1;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (int i = 0; i < 50 && b; i++)
    begin
      @(posedge clk);
      aw = aw && !s_axi_awready;
      w = w && !s_axi_wready;
      if (b && s_axi_bvalid)
        chk(32'(s_axi_bresp), 32'(SRS_RESP_OKAY));
      b = b && !s_axi_bvalid;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
      s_axi_bready <= b;
    end
    tmo(b);
  endtask

  // Bus read: data and response taken at the edge that sees rvalid
  task automatic axr(input logic [31:0] a, output logic [31:0] d,
    output logic [1:0] r);
    logic ar, rd;
    ar = 1;
    rd = 1;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (int i = 0; i < 50 && rd; i++)
    begin
      @(posedge clk);
      ar = ar && !s_axi_arready;
      d = s_axi_rdata;
      r = s_axi_rresp;
      rd = rd && !s_axi_rvalid;
      s_axi_arvalid <= ar;
      s_axi_rready <= rd;
    end
    tmo(rd);
  endtask

  // Fundamental reset with new straps, then release
  task automatic boot(input logic [10:0] c);
    @(posedge clk);
    rel <= 0;
    cfg <= c;
    repeat (3) @(posedge clk);
    chk({core_reset, link_reset, run_normal}, 3'b110);
    rel <= 1;
    repeat (8) @(posedge clk);
  endtask

  // Measures the distance between two master bus ticks
  task automatic gap(input logic [9:0] exp);
    int n;
    n = 1;
    for (int i = 0; i < 1100 && !master_bus_tick; i++)
      @(posedge clk);
    tmo(!master_bus_tick);
    @(posedge clk);
    for (int i = 0; i < 1100 && !master_bus_tick; i++)
    begin
      @(posedge clk);
      n++;
    end
    tmo(!master_bus_tick);
    chk(n, 32'(exp));
  endtask

  // Main sequence
  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (6) @(posedge clk);
    reset <= 0;
    for (int k = 0; k < 4; k++)
    begin
      boot(rows[k][22:12]);
      chk({up_sclk, dn_sclk, eeprom_load_en, mode_reserved,
        eeprom_dev_addr}, rows[k][11:0]);
      chk({core_reset, run_normal}, 2'b01);
      gap(rows[k][15] ? SRS_SLOW_DIV : SRS_FAST_DIV);
      $display("strap row %0d done", k);
    end
    // Held in reset: registers reachable, then released by software
    boot({4'h0, 3'h0, 4'b0110});
    chk({core_reset, run_normal, up_sclk, dn_sclk}, 5'b10100);
    axr(32'(SRS_CTRL_OFF), d, r);
    chk({r, d[0]}, 3'b001);
    axw(32'(SRS_UP_LSTS_OFF), 32'h0000_0000);
    axw(32'(SRS_DN0_LSTS_OFF), 32'h0000_1000);
    axr(32'(SRS_UP_LSTS_OFF), d, r);
    chk({r, d[12]}, 3'b000);
    axr(32'(SRS_DN0_LSTS_OFF), d, r);
    chk({r, d[12], up_sclk, dn_sclk}, 6'b001001);
    axr(32'h0000_0040, d, r);
    chk(r, SRS_RESP_SLVERR);
    axw(32'(SRS_STRAP_OFF), 32'hFFFF_FFFF);
    axw(32'(SRS_CTRL_OFF), 32'h0000_0000);
    for (int i = 0; i < 10 && !run_normal; i++)
      @(posedge clk);
    tmo(!run_normal);
    chk({core_reset, run_normal}, 2'b01);
    gap(SRS_FAST_DIV);
    $display("hold and release test done");
    results();
  end
endmodule // srs_top_tb
